/* pm_activity_pkg.sv */
// constants for the power-management activity monitor
`default_nettype none
package pm_activity_pkg;
    // ------------------------------------------------------------
    // configuration space offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ACT_STS = 8'h00;
    localparam logic [7:0] ADDR_ACT_EN = 8'h01;
    localparam logic [7:0] ADDR_PER_EN = 8'h02;
    localparam logic [7:0] ADDR_CTRL = 8'h03;
    localparam logic [7:0] ADDR_GLOBAL_EVENT_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_GBL_STS = 8'h05;
    localparam logic [7:0] ADDR_PRI_CH_LO = 8'h06;
    localparam logic [7:0] ADDR_PRI_CH_HI = 8'h07;
    localparam logic [7:0] ADDR_SEC_CH_LO = 8'h08;
    localparam logic [7:0] ADDR_SEC_CH_HI = 8'h09;
    localparam logic [7:0] ADDR_INIT_A_LO = 8'h0A;
    localparam logic [7:0] ADDR_INIT_A_HI = 8'h0B;
    localparam logic [7:0] ADDR_INIT_B_LO = 8'h0C;
    localparam logic [7:0] ADDR_INIT_B_HI = 8'h0D;
    localparam logic [7:0] ADDR_CNT_A_LO = 8'h0E;
    localparam logic [7:0] ADDR_CNT_A_HI = 8'h0F;
    localparam logic [7:0] ADDR_CNT_B_LO = 8'h10;
    localparam logic [7:0] ADDR_CNT_B_HI = 8'h11;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_KBD = 7;
    localparam int BIT_SERIAL = 6;
    localparam int BIT_PARALLEL = 5;
    localparam int BIT_VIDEO = 4;
    localparam int BIT_DISK = 3;
    localparam int BIT_RSVD = 2;
    localparam int BIT_PIRQ = 1;
    localparam int BIT_DMA = 0;
    localparam logic [7:0] PER_MASK = 8'hD8;
    localparam logic [7:0] ACT_MASK = 8'hFB;
    // control register
    localparam int CTRL_START_A = 0;
    localparam int CTRL_START_B = 1;
    localparam int CTRL_AUTO_A = 2;
    localparam int CTRL_AUTO_B = 3;
    localparam int CTRL_PRI_RELOAD_A = 4;
    localparam int CTRL_PIRQ_RELOAD = 5;
    localparam logic [7:0] CTRL_MASK = 8'h3C;
    // global enable and status
    localparam int GBL_TO_A = 0;
    localparam int GBL_TO_B = 1;
    localparam int GBL_PACT = 2;
    localparam int GBL_W = 3;

    // ------------------------------------------------------------
    // reset values and decode ranges
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] IO_KBD = 16'h0060;
    localparam logic [15:0] IO_COM1_LO = 16'h03F8;
    localparam logic [15:0] IO_COM1_HI = 16'h03FF;
    localparam logic [15:0] IO_COM2_LO = 16'h02F8;
    localparam logic [15:0] IO_COM2_HI = 16'h02FF;
    localparam logic [15:0] IO_COM3_LO = 16'h03E8;
    localparam logic [15:0] IO_COM3_HI = 16'h03EF;
    localparam logic [15:0] IO_COM4_LO = 16'h02E8;
    localparam logic [15:0] IO_COM4_HI = 16'h02EF;
    localparam logic [15:0] IO_LPT1_LO = 16'h0378;
    localparam logic [15:0] IO_LPT1_HI = 16'h037F;
    localparam logic [15:0] IO_LPT2_LO = 16'h0278;
    localparam logic [15:0] IO_LPT2_HI = 16'h027F;
    localparam logic [15:0] IO_VGA_LO = 16'h03B0;
    localparam logic [15:0] IO_VGA_HI = 16'h03DF;
    localparam logic [15:0] IO_HD1_LO = 16'h01F0;
    localparam logic [15:0] IO_HD1_HI = 16'h01F7;
    localparam logic [15:0] IO_HD2_LO = 16'h0170;
    localparam logic [15:0] IO_HD2_HI = 16'h0177;
    localparam logic [15:0] IO_FDC = 16'h03F5;
    localparam logic [19:0] MEM_AB_LO = 20'hA0000;
    localparam logic [19:0] MEM_AB_HI = 20'hBFFFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TIMER_W = 16;
    localparam int CLK_MHZ = 125;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS * CLK_MHZ / 1000;
endpackage
`default_nettype wire

/* pm_activity_monitor.sv */
// power-management activity monitor with two idle timers
// ------------------------------------------------------------
// ------------------------------------------------------------
`default_nettype none
module pm_activity_monitor #(
    parameter int TICK_CYCLES = pm_activity_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic io_cycle,
    input wire logic mem_cycle,
    input wire logic [19:0] cyc_addr,
    input wire logic [15:0] irq_req,
    input wire logic isa_master_dma,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic smi_req,
    output logic timer_a_timeout,
    output logic timer_b_timeout
);
    localparam int TW = pm_activity_pkg::TIMER_W;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [TW-1:0] CNT_ONE = TW'(1);
    localparam logic [TW-1:0] RST_CNT = '0;

    typedef struct packed {
        logic [7:0] act_sts;
        logic [7:0] act_en;
        logic [7:0] per_en;
        logic [7:0] ctrl;
        logic [pm_activity_pkg::GBL_W-1:0] global_event_enable;
        logic [pm_activity_pkg::GBL_W-1:0] gbl_sts;
        logic [15:0] pri_ch;
        logic [15:0] sec_ch;
        logic [1:0][TW-1:0] init;
        logic [1:0][TW-1:0] cnt;
        logic [1:0] run;
        logic [1:0] tout;
        logic [15:0] tick_cnt;
        logic [7:0] rdata;
        logic smi;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    logic [15:0] io_a;
    logic [7:0] hit;
    logic [7:0] pri_hit;
    logic [7:0] per_hit;
    logic [1:0] reload;
    logic tick;

    assign io_a = cyc_addr[15:0];

    always_comb begin
        hit = 8'h00;
        hit[pm_activity_pkg::BIT_KBD] = io_cycle && (io_a == pm_activity_pkg::IO_KBD);
        hit[pm_activity_pkg::BIT_SERIAL] = io_cycle && (
            in_rng(io_a, pm_activity_pkg::IO_COM1_LO, pm_activity_pkg::IO_COM1_HI) ||
            in_rng(io_a, pm_activity_pkg::IO_COM2_LO, pm_activity_pkg::IO_COM2_HI) ||
            in_rng(io_a, pm_activity_pkg::IO_COM3_LO, pm_activity_pkg::IO_COM3_HI) ||
            in_rng(io_a, pm_activity_pkg::IO_COM4_LO, pm_activity_pkg::IO_COM4_HI));
        hit[pm_activity_pkg::BIT_PARALLEL] = io_cycle && (
            in_rng(io_a, pm_activity_pkg::IO_LPT1_LO, pm_activity_pkg::IO_LPT1_HI) ||
            in_rng(io_a, pm_activity_pkg::IO_LPT2_LO, pm_activity_pkg::IO_LPT2_HI));
        hit[pm_activity_pkg::BIT_VIDEO] =
            (io_cycle && in_rng(io_a, pm_activity_pkg::IO_VGA_LO, pm_activity_pkg::IO_VGA_HI)) ||
            (mem_cycle && (cyc_addr >= pm_activity_pkg::MEM_AB_LO) &&
             (cyc_addr <= pm_activity_pkg::MEM_AB_HI));
        hit[pm_activity_pkg::BIT_DISK] = io_cycle && (
            in_rng(io_a, pm_activity_pkg::IO_HD1_LO, pm_activity_pkg::IO_HD1_HI) ||
            in_rng(io_a, pm_activity_pkg::IO_HD2_LO, pm_activity_pkg::IO_HD2_HI) ||
            (io_a == pm_activity_pkg::IO_FDC));
        // a channel set in both registers counts as primary
        hit[pm_activity_pkg::BIT_PIRQ] = |(irq_req & state_r.pri_ch);
        hit[pm_activity_pkg::BIT_DMA] = isa_master_dma;
    end

    // ------------------------------------------------------------
    // reload causes
    // ------------------------------------------------------------
    always_comb begin
        pri_hit = hit & state_r.act_en & pm_activity_pkg::ACT_MASK;
        if (!state_r.ctrl[pm_activity_pkg::CTRL_PIRQ_RELOAD]) begin
            pri_hit[pm_activity_pkg::BIT_PIRQ] = 1'b0;
        end
        per_hit = hit & state_r.per_en & pm_activity_pkg::PER_MASK;
        reload[0] = state_r.run[0] && state_r.ctrl[pm_activity_pkg::CTRL_PRI_RELOAD_A] && (|pri_hit);
        reload[1] = state_r.run[1] && (|per_hit);
    end

    assign tick = (state_r.tick_cnt == TICK_LAST);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] sts_set;
        logic [7:0] sts_clr;
        logic [pm_activity_pkg::GBL_W-1:0] gbl_set;
        logic [pm_activity_pkg::GBL_W-1:0] gbl_clr;
        logic [1:0] start_wr;
        logic [1:0] auto_en;
        sts_set = 8'h00;
        sts_clr = 8'h00;
        gbl_set = '0;
        gbl_clr = '0;
        start_wr = 2'b00;
        auto_en = {state_r.ctrl[pm_activity_pkg::CTRL_AUTO_B], state_r.ctrl[pm_activity_pkg::CTRL_AUTO_A]};
        state_nxt = state_r;
        state_nxt.tout = 2'b00;
        state_nxt.tick_cnt = tick ? 16'h0000 : state_r.tick_cnt + 16'h0001;

        // register writes
        if (cfg_wr) begin
            case (cfg_addr)
                pm_activity_pkg::ADDR_ACT_STS: sts_clr = cfg_wdata;
                pm_activity_pkg::ADDR_ACT_EN: state_nxt.act_en = cfg_wdata & pm_activity_pkg::ACT_MASK;
                pm_activity_pkg::ADDR_PER_EN: state_nxt.per_en = cfg_wdata & pm_activity_pkg::PER_MASK;
                pm_activity_pkg::ADDR_CTRL: begin
                    state_nxt.ctrl = cfg_wdata & pm_activity_pkg::CTRL_MASK;
                    start_wr = {cfg_wdata[pm_activity_pkg::CTRL_START_B], cfg_wdata[pm_activity_pkg::CTRL_START_A]};
                end
                pm_activity_pkg::ADDR_GLOBAL_EVENT_ENABLE: state_nxt.global_event_enable = cfg_wdata[pm_activity_pkg::GBL_W-1:0];
                pm_activity_pkg::ADDR_GBL_STS: gbl_clr = cfg_wdata[pm_activity_pkg::GBL_W-1:0];
                pm_activity_pkg::ADDR_PRI_CH_LO: state_nxt.pri_ch[7:0] = cfg_wdata;
                pm_activity_pkg::ADDR_PRI_CH_HI: state_nxt.pri_ch[15:8] = cfg_wdata;
                pm_activity_pkg::ADDR_SEC_CH_LO: state_nxt.sec_ch[7:0] = cfg_wdata;
                pm_activity_pkg::ADDR_SEC_CH_HI: state_nxt.sec_ch[15:8] = cfg_wdata;
                pm_activity_pkg::ADDR_INIT_A_LO: state_nxt.init[0][7:0] = cfg_wdata;
                pm_activity_pkg::ADDR_INIT_A_HI: state_nxt.init[0][15:8] = cfg_wdata;
                pm_activity_pkg::ADDR_INIT_B_LO: state_nxt.init[1][7:0] = cfg_wdata;
                pm_activity_pkg::ADDR_INIT_B_HI: state_nxt.init[1][15:8] = cfg_wdata;
                default: begin
                end
            endcase
        end

        // both timers share one countdown path
        for (int i = 0; i < 2; i++) begin
            if (cfg_wr && (cfg_addr == pm_activity_pkg::ADDR_CTRL) && !start_wr[i]) begin
                state_nxt.run[i] = 1'b0;
            end else if (start_wr[i] && !state_r.run[i]) begin
                state_nxt.run[i] = 1'b1;
                state_nxt.cnt[i] = state_r.init[i];
            end else if (reload[i]) begin
                // reload beats a tick in the same cycle
                state_nxt.cnt[i] = state_r.init[i];
            end else if (state_r.run[i] && tick) begin
                if (state_r.cnt[i] <= CNT_ONE) begin
                    state_nxt.tout[i] = 1'b1;
                    state_nxt.cnt[i] = auto_en[i] ? state_r.init[i] : RST_CNT;
                    state_nxt.run[i] = auto_en[i];
                end else begin
                    state_nxt.cnt[i] = state_r.cnt[i] - CNT_ONE;
                end
            end
        end

        // status recording
        if (reload[0]) begin
            sts_set = sts_set | pri_hit;
        end
        if (reload[1]) begin
            sts_set = sts_set | per_hit;
        end
        gbl_set[pm_activity_pkg::GBL_TO_A] = state_nxt.tout[0];
        gbl_set[pm_activity_pkg::GBL_TO_B] = state_nxt.tout[1];
        // event smi does not wait for the reload path
        gbl_set[pm_activity_pkg::GBL_PACT] = (|pri_hit) && state_r.global_event_enable[pm_activity_pkg::GBL_PACT];

        // set wins over a clear landing in the same cycle
        state_nxt.act_sts = ((state_r.act_sts & ~sts_clr) | sts_set) & pm_activity_pkg::ACT_MASK;
        state_nxt.gbl_sts = (state_r.gbl_sts & ~gbl_clr) | gbl_set;
        state_nxt.smi = |(state_nxt.gbl_sts & state_r.global_event_enable);

        // register reads, answered one cycle later
        state_nxt.rdata = pm_activity_pkg::RST_BYTE;
        if (cfg_rd) begin
            case (cfg_addr)
                pm_activity_pkg::ADDR_ACT_STS: state_nxt.rdata = state_r.act_sts;
                pm_activity_pkg::ADDR_ACT_EN: state_nxt.rdata = state_r.act_en;
                pm_activity_pkg::ADDR_PER_EN: state_nxt.rdata = state_r.per_en;
                pm_activity_pkg::ADDR_CTRL: begin
                    state_nxt.rdata = state_r.ctrl;
                    state_nxt.rdata[pm_activity_pkg::CTRL_START_A] = state_r.run[0];
                    state_nxt.rdata[pm_activity_pkg::CTRL_START_B] = state_r.run[1];
                end
                pm_activity_pkg::ADDR_GLOBAL_EVENT_ENABLE: state_nxt.rdata = 8'(state_r.global_event_enable);
                pm_activity_pkg::ADDR_GBL_STS: state_nxt.rdata = 8'(state_r.gbl_sts);
                pm_activity_pkg::ADDR_PRI_CH_LO: state_nxt.rdata = state_r.pri_ch[7:0];
                pm_activity_pkg::ADDR_PRI_CH_HI: state_nxt.rdata = state_r.pri_ch[15:8];
                pm_activity_pkg::ADDR_SEC_CH_LO: state_nxt.rdata = state_r.sec_ch[7:0];
                pm_activity_pkg::ADDR_SEC_CH_HI: state_nxt.rdata = state_r.sec_ch[15:8];
                pm_activity_pkg::ADDR_INIT_A_LO: state_nxt.rdata = state_r.init[0][7:0];
                pm_activity_pkg::ADDR_INIT_A_HI: state_nxt.rdata = state_r.init[0][15:8];
                pm_activity_pkg::ADDR_INIT_B_LO: state_nxt.rdata = state_r.init[1][7:0];
                pm_activity_pkg::ADDR_INIT_B_HI: state_nxt.rdata = state_r.init[1][15:8];
                pm_activity_pkg::ADDR_CNT_A_LO: state_nxt.rdata = state_r.cnt[0][7:0];
                pm_activity_pkg::ADDR_CNT_A_HI: state_nxt.rdata = state_r.cnt[0][15:8];
                pm_activity_pkg::ADDR_CNT_B_LO: state_nxt.rdata = state_r.cnt[1][7:0];
                pm_activity_pkg::ADDR_CNT_B_HI: state_nxt.rdata = state_r.cnt[1][15:8];
                default: state_nxt.rdata = pm_activity_pkg::RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg_rdata = state_r.rdata;
    assign smi_req = state_r.smi;
    assign timer_a_timeout = state_r.tout[0];
    assign timer_b_timeout = state_r.tout[1];
endmodule
`default_nettype wire

/* pm_activity_monitor_properties.sv */
// port checker for the activity monitor
`default_nettype none
module pm_activity_checker #(
    parameter int TICK_CYCLES = 2
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic io_cycle,
    input wire logic mem_cycle,
    input wire logic [19:0] cyc_addr,
    input wire logic [15:0] irq_req,
    input wire logic isa_master_dma,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic smi_req,
    input wire logic timer_a_timeout,
    input wire logic timer_b_timeout
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    read_idle_a: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
        else $error("read data not zero without a read");
    status_rsvd_a: assert property ($past(cfg_rd && cfg_addr <= pm_activity_pkg::ADDR_ACT_EN) |-> !cfg_rdata[2])
        else $error("reserved activity bit reads one");
    per_mask_a: assert property ($past(cfg_rd && cfg_addr == pm_activity_pkg::ADDR_PER_EN)
        |-> (cfg_rdata & ~pm_activity_pkg::PER_MASK) == 8'h00) else $error("peripheral enable reserved bit set");
    unmapped_read_a: assert property ($past(cfg_rd && cfg_addr > pm_activity_pkg::ADDR_CNT_B_HI)
        |-> cfg_rdata == 8'h00) else $error("unmapped offset reads nonzero");
    // ------------------------------------------------------------
    // timeouts and management interrupt
    // ------------------------------------------------------------
    pulse_a_a: assert property (timer_a_timeout |=> !timer_a_timeout) else $error("timer a pulse too long");
    pulse_b_a: assert property (timer_b_timeout ##1 1'b1 |-> !timer_b_timeout) else $error("timer b pulse too long");
    // an enable write reaches smi_req one cycle later than a status write
    smi_cause_a: assert property ($rose(smi_req) |-> timer_a_timeout || timer_b_timeout
        || $past(cfg_wr || io_cycle || mem_cycle || isa_master_dma || (|irq_req)) || $past(cfg_wr, 2))
        else $error("smi rose uncaused");
    smi_hold_a: assert property ($fell(smi_req) |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("smi fell without a write");
    cover property (timer_a_timeout);
    cover property (timer_b_timeout);
    cover property ($rose(smi_req));
endmodule
bind pm_activity_monitor pm_activity_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
    .sys_clk(sys_clk), .rstn(rstn), .io_cycle(io_cycle), .mem_cycle(mem_cycle), .cyc_addr(cyc_addr),
    .irq_req(irq_req), .isa_master_dma(isa_master_dma), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .smi_req(smi_req), .timer_a_timeout(timer_a_timeout),
    .timer_b_timeout(timer_b_timeout));
`default_nettype wire

/* host_activity_model.sv */
// far-side model: host bus cycles and interrupt lines
`default_nettype none
module host_activity_model (
    input wire logic sys_clk,
    output var logic io_cycle,
    output var logic mem_cycle,
    output var logic [19:0] cyc_addr,
    output var logic [15:0] irq_req,
    output var logic isa_master_dma
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {io_cycle, mem_cycle, isa_master_dma, irq_req} = '0;
        cyc_addr = 20'hFFFFF;
    end
    // kind 0 i/o, 1 memory, 2 master or dma; one observed cycle each
    task automatic access(input logic [1:0] kind, input logic [19:0] a);
        @(posedge sys_clk);
        io_cycle <= kind == 2'd0;
        mem_cycle <= kind == 2'd1;
        isa_master_dma <= kind == 2'd2;
        cyc_addr <= a;
        @(posedge sys_clk);
        {io_cycle, mem_cycle, isa_master_dma} <= 3'b000;
        // released address shows the inverse so a stale value cannot match
        cyc_addr <= ~a;
    endtask
    task automatic irq(input int ch);
        @(posedge sys_clk);
        irq_req <= 16'h0001 << ch;
        @(posedge sys_clk);
        irq_req <= 16'h0000;
    endtask
endmodule
`default_nettype wire

/* test_pm_activity_monitor.sv */
// self-checking bench for the activity monitor
`default_nettype none
module test_pm_activity_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rstn, cfg_wr, cfg_rd, smi_req, timer_a_timeout, timer_b_timeout, io_cycle, mem_cycle, isa_master_dma;
    logic io;
    logic [19:0] cyc_addr, a;
    logic [15:0] irq_req;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
    int fails, compares, na, nb, n0;
    logic [19:0] corner [16] = '{20'h00060, 20'h003F8, 20'h003FF, 20'h002F8, 20'h002EF, 20'h003E8, 20'h00378,
        20'h0027F, 20'h003B0, 20'h003DF, 20'h001F0, 20'h00177, 20'h003F5, 20'h00061, 20'h002F7, 20'h00400};
    logic [19:0] mem_c [4] = '{20'hA0000, 20'hBFFFF, 20'h9FFFF, 20'hC0000};
    pm_activity_monitor #(.TICK_CYCLES(2)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .io_cycle(io_cycle),
        .mem_cycle(mem_cycle), .cyc_addr(cyc_addr), .irq_req(irq_req), .isa_master_dma(isa_master_dma),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .smi_req(smi_req), .timer_a_timeout(timer_a_timeout), .timer_b_timeout(timer_b_timeout));
    host_activity_model u_host (.sys_clk(sys_clk), .io_cycle(io_cycle), .mem_cycle(mem_cycle),
        .cyc_addr(cyc_addr), .irq_req(irq_req), .isa_master_dma(isa_master_dma));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (timer_a_timeout === 1'b1) na <= na + 1;
        if (timer_b_timeout === 1'b1) nb <= nb + 1;
    end
    function automatic logic in_r(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
        return v >= lo && v <= hi;
    endfunction
    function automatic logic [7:0] hits(input logic is_io, input logic [19:0] v);
        logic [7:0] h;
        h = 8'h00;
        if (is_io) begin
            h[7] = v == 20'h00060;
            h[6] = in_r(v, 20'h003F8, 20'h003FF) || in_r(v, 20'h002F8, 20'h002FF) || in_r(v, 20'h003E8, 20'h003EF)
                || in_r(v, 20'h002E8, 20'h002EF);
            h[5] = in_r(v, 20'h00378, 20'h0037F) || in_r(v, 20'h00278, 20'h0027F);
            h[4] = in_r(v, 20'h003B0, 20'h003DF);
            h[3] = in_r(v, 20'h001F0, 20'h001F7) || in_r(v, 20'h00170, 20'h00177) || v == 20'h003F5;
        end else h[4] = in_r(v, 20'hA0000, 20'hBFFFF);
        return h;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        cfg_wr <= 1'b1;
        cfg_addr <= ad;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [7:0] ad, input logic [7:0] exp);
        @(posedge sys_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= ad;
        @(posedge sys_clk);
        cfg_rd <= 1'b0;
        #1;
        check(what, 16'(cfg_rdata), 16'(exp));
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end
    initial begin
        {rstn, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
        void'($urandom(79));
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i <= 18; i++) rd("reset value", i[7:0], 8'h00);
        wr(8'h01, 8'hFF);
        rd("activity enable", 8'h01, 8'hFB);
        wr(8'h02, 8'hFF);
        rd("peripheral enable", 8'h02, 8'hD8);
        wr(8'h40, 8'hFF);
        rd("unmapped", 8'h40, 8'h00);
        $display("register test done");
        wr(8'h0A, 8'hFF);
        wr(8'h0B, 8'hFF);
        wr(8'h03, 8'h31);
        for (int i = 0; i < 40; i++) begin
            a = (i < 16) ? corner[i] : (i < 20) ? mem_c[i - 16] : 20'($urandom_range(1023));
            io = i < 16 || i >= 20;
            wr(8'h00, 8'hFF);
            u_host.access(io ? 2'd0 : 2'd1, a);
            rd("decoded status", 8'h00, hits(io, a));
        end
        wr(8'h00, 8'hFF);
        u_host.access(2'd2, 20'h00000);
        u_host.access(2'd0, 20'h00060);
        rd("held status", 8'h00, 8'h81);
        wr(8'h06, 8'h20);
        wr(8'h09, 8'h02);
        wr(8'h00, 8'hFF);
        u_host.irq(5);
        rd("primary irq", 8'h00, 8'h02);
        wr(8'h00, 8'hFF);
        u_host.irq(9);
        rd("secondary irq", 8'h00, 8'h00);
        wr(8'h03, 8'h11);
        u_host.irq(5);
        rd("irq reload off", 8'h00, 8'h00);
        wr(8'h03, 8'h01);
        u_host.access(2'd0, 20'h00060);
        rd("reload off", 8'h00, 8'h00);
        $display("event test done");
        wr(8'h04, 8'h04);
        u_host.access(2'd0, 20'h00060);
        #1;
        check("event smi", 16'(smi_req), 16'h0001);
        rd("global status", 8'h05, 8'h04);
        wr(8'h05, 8'h04);
        repeat (2) @(posedge sys_clk);
        #1;
        check("smi cleared", 16'(smi_req), 16'h0000);
        wr(8'h04, 8'h01);
        wr(8'h03, 8'h00);
        wr(8'h0A, 8'h03);
        wr(8'h0B, 8'h00);
        n0 = na;
        wr(8'h03, 8'h11);
        repeat (10) u_host.access(2'd0, 20'h00060);
        check("timeout under activity", 16'(na - n0), 16'h0000);
        repeat (12) @(posedge sys_clk);
        #1;
        check("idle timeout a", 16'(na - n0), 16'h0001);
        check("timeout smi", 16'(smi_req), 16'h0001);
        wr(8'h05, 8'hFF);
        n0 = na;
        wr(8'h03, 8'h05);
        repeat (22) @(posedge sys_clk);
        #1;
        check("auto reload", 16'(na - n0 >= 3), 16'h0001);
        wr(8'h03, 8'h00);
        $display("timer a test done");
        wr(8'h02, 8'h08);
        wr(8'h0C, 8'h03);
        wr(8'h00, 8'hFF);
        n0 = nb;
        wr(8'h03, 8'h02);
        repeat (10) u_host.access(2'd0, 20'h00060);
        check("unselected activity", 16'(nb - n0), 16'h0001);
        n0 = nb;
        wr(8'h03, 8'h02);
        repeat (10) u_host.access(2'd0, 20'h001F0);
        check("selected activity", 16'(nb - n0), 16'h0000);
        rd("peripheral status", 8'h00, 8'h08);
        repeat (12) @(posedge sys_clk);
        #1;
        check("idle timeout b", 16'(nb - n0), 16'h0001);
        n0 = nb;
        wr(8'h03, 8'h0A);
        repeat (22) @(posedge sys_clk);
        #1;
        check("auto reload b", 16'(nb - n0 >= 3), 16'h0001);
        $display("timer b test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
